// [shared/ubrg_pkg.sv]
package ubrg_pkg;
   // clock source select codes
   localparam logic [1:0] SRC_MASTER = 2'h0;
   localparam logic [1:0] SRC_MASTER_DIV = 2'h1;
   localparam logic [1:0] SRC_MASTER_ALT = 2'h2;
   localparam logic [1:0] SRC_EXT_PIN = 2'h3;
   localparam int PRESCALE_DIV = 8;
   localparam int DIVISOR_WIDTH = 16;
   localparam int FRACTION_WIDTH = 3;
   localparam int FRACTION_STEPS = 8;
   localparam int OVERSAMPLE_HIGH = 16;
   localparam int OVERSAMPLE_LOW = 8;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;
   localparam logic [2:0] FRACTION_RESET = 3'h0;
   localparam logic [1:0] SOURCE_RESET = 2'h0;
endpackage : ubrg_pkg

// [shared/ubrg_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ubrg_tick_if;
   logic enable;
   logic tick;
   logic [15:0] divisor;
   logic [2:0] fraction;
   logic frac_on;
   logic half_tick;
   modport master (output enable, output divisor, output fraction, output frac_on,
      input tick, input half_tick);
   modport divider (input enable, input divisor, input fraction, input frac_on,
      output tick, output half_tick);
endinterface : ubrg_tick_if
`default_nettype wire

// [design/ubrg_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module ubrg_prescaler #(
   parameter int DIV = ubrg_pkg::PRESCALE_DIV
) (
   input wire logic clk_in,     // master clock
   input wire logic rst_n_in,   // synchronised reset
   input wire logic run_in,     // peripheral clock enable
   output logic pulse_out       // one pulse every DIV cycles
);
   logic [7:0] cnt_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 8'h00;
         pulse_out <= 1'b0;
      end else if (run_in) begin
         pulse_out <= (cnt_r == 8'(DIV - 1));
         cnt_r <= (cnt_r == 8'(DIV - 1)) ? 8'h00 : cnt_r + 8'h01;
      end else begin
         pulse_out <= 1'b0;
      end
   end
endmodule : ubrg_prescaler
`default_nettype wire

// [design/ubrg_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module ubrg_divider (
   input wire logic clk_in,         // master clock
   input wire logic rst_n_in,       // synchronised reset
   input wire logic src_tick_in,    // selected source edge, one cycle
   ubrg_tick_if.divider port_if     // divisor settings and output tick
);
   logic [15:0] cnt_r;
   logic [2:0] phase_r;
   logic extra_r;
   logic [15:0] period;
   logic [3:0] acc;

   // fractional: stretch a period when the running accumulator carries
   assign acc = {1'b0, phase_r} + {1'b0, port_if.fraction};
   assign period = port_if.divisor + {15'h0000, extra_r};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 16'h0000;
         phase_r <= 3'h0;
         extra_r <= 1'b0;
         port_if.tick <= 1'b0;
         port_if.half_tick <= 1'b0;
      end else if (!port_if.enable || port_if.divisor == 16'h0000) begin // see [RQ3]
         port_if.tick <= 1'b0;
         port_if.half_tick <= 1'b0;
      end else if (src_tick_in) begin
         port_if.half_tick <= (cnt_r == (period >> 1) - 16'h0001) && period != 16'h0001;
         if (cnt_r >= period - 16'h0001) begin // see [RQ2] [RQ4]
            cnt_r <= 16'h0000;
            port_if.tick <= 1'b1; // see [RQ18]
            if (port_if.frac_on) begin // see [RQ8] [RQ19]
               phase_r <= acc[2:0];
               extra_r <= acc[3];
            end else begin
               phase_r <= 3'h0;
               extra_r <= 1'b0;
            end
         end else begin
            cnt_r <= cnt_r + 16'h0001;
            port_if.tick <= 1'b0;
         end
      end else begin
         port_if.tick <= 1'b0;
         port_if.half_tick <= 1'b0;
      end
   end
endmodule : ubrg_divider
`default_nettype wire

// [design/ubrg_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] source: master, master over eight, pin
// [RQ2] sixteen-bit integer divisor divides source
// [RQ3] divisor zero stops all output ticks; sync external bit tick still follows the pin
// [RQ4] divisor one passes source straight through
// [RQ5] external clock below master over 4.5
// [RQ6] async: sample tick, then divide 16/8
// [RQ7] oversample bit one gives eight samples
// [RQ8] nonzero fraction adds eighths to divisor
// [RQ9] fraction only in normal async mode
// [RQ10] sync internal: bit tick is divided clock
// [RQ11] sync external: pin drives bit tick directly
// [RQ12] master source sync: serial clock 50:50; odd divisors above one stay high less than half
// [RQ13] software uses even divisor otherwise
// [RQ14] clock gating freezes and resumes state; serial clock still toggles in sync master-source divisor-one bypass
// [RQ15] settings accepted while clock gated
// [RQ16] interrupt line treated level sensitive
// [RQ17] software keeps baud error within 5%
// [RQ18] outputs are one-cycle enable pulses
// [RQ19] fraction stretches periods within eight
module ubrg_top (
   input wire logic clock_in,             // master clock, 100 MHz
   input wire logic arst_n_in,            // async reset, active low
   input wire logic clk_run_in,           // peripheral clock enabled
   input wire logic [1:0] clock_source_select_in, // source select code
   input wire logic [15:0] integer_divisor_in,    // integer divisor
   input wire logic [2:0] fraction_eighths_in,    // fractional eighths
   input wire logic sync_mode_in,         // 1 synchronous, 0 asynchronous
   input wire logic oversample8_in,       // 1 eight samples per bit
   input wire logic normal_mode_in,       // port in normal mode
   input wire logic serial_clock_in,      // serial clock pin level
   output logic sample_tick_out,          // receiver sampling pulse
   output logic bit_tick_out,             // bit-rate pulse
   output logic serial_clock_out,         // serial clock pin drive
   output logic serial_clock_oe_out       // serial clock pin enable
);
   logic rst_s1_r;
   logic rst_n_r;
   logic [1:0] src_sel_r;
   logic [15:0] div_r;
   logic [2:0] frac_r;
   logic sync_r;
   logic over_r;
   logic normal_r;
   logic pin_d_r;
   logic pre_pulse;
   logic src_tick;
   logic ext_src;
   logic [3:0] os_cnt_r;
   logic [3:0] os_last;
   ubrg_tick_if tick_if ();

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // settings latch every cycle, gated or not
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         src_sel_r <= ubrg_pkg::SOURCE_RESET;
         div_r <= ubrg_pkg::DIVISOR_RESET;
         frac_r <= ubrg_pkg::FRACTION_RESET;
         sync_r <= 1'b0;
         over_r <= 1'b0;
         normal_r <= 1'b1;
      end else begin // see [RQ15]
         src_sel_r <= clock_source_select_in;
         div_r <= integer_divisor_in;
         frac_r <= fraction_eighths_in;
         sync_r <= sync_mode_in;
         over_r <= oversample8_in;
         normal_r <= normal_mode_in;
      end
   end

   // rising edge of pin; pin is slow vs master clock
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_d_r <= 1'b0;
      end else begin
         pin_d_r <= serial_clock_in; // see [RQ5]
      end
   end

   ubrg_prescaler #(
      .DIV(ubrg_pkg::PRESCALE_DIV)
   ) u_pre (
      .clk_in(clock_in),
      .rst_n_in(rst_n_r),
      .run_in(clk_run_in),
      .pulse_out(pre_pulse)
   );

   assign ext_src = (src_sel_r == ubrg_pkg::SRC_EXT_PIN);

   always_comb begin
      unique case (src_sel_r) // see [RQ1]
         ubrg_pkg::SRC_MASTER: src_tick = clk_run_in;
         ubrg_pkg::SRC_MASTER_DIV: src_tick = pre_pulse;
         ubrg_pkg::SRC_MASTER_ALT: src_tick = pre_pulse;
         ubrg_pkg::SRC_EXT_PIN: src_tick = clk_run_in && serial_clock_in && !pin_d_r;
         default: src_tick = 1'b0;
      endcase
   end

   // gating only holds counters; nothing clears on clock stop
   assign tick_if.enable = clk_run_in; // see [RQ14]
   assign tick_if.divisor = div_r;
   assign tick_if.fraction = frac_r;
   assign tick_if.frac_on = (frac_r != 3'h0) && !sync_r && normal_r; // see [RQ8] [RQ9]

   ubrg_divider u_div (
      .clk_in(clock_in),
      .rst_n_in(rst_n_r),
      .src_tick_in(src_tick),
      .port_if(tick_if)
   );

   assign os_last = over_r ? 4'(ubrg_pkg::OVERSAMPLE_LOW - 1)
      : 4'(ubrg_pkg::OVERSAMPLE_HIGH - 1); // see [RQ7]

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         os_cnt_r <= 4'h0;
      end else if (!sync_r && tick_if.tick) begin // see [RQ6]
         os_cnt_r <= (os_cnt_r >= os_last) ? 4'h0 : os_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sample_tick_out <= 1'b0;
         bit_tick_out <= 1'b0;
      end else if (!sync_r) begin
         sample_tick_out <= tick_if.tick; // see [RQ6]
         bit_tick_out <= tick_if.tick && (os_cnt_r >= os_last);
      end else if (ext_src) begin
         sample_tick_out <= 1'b0;
         bit_tick_out <= clk_run_in && serial_clock_in && !pin_d_r; // see [RQ11]
      end else begin
         sample_tick_out <= 1'b0;
         bit_tick_out <= tick_if.tick; // see [RQ10]
      end
   end

   // sync internal source: drive pin; fall at half period keeps even divisors 50:50
   always_ff @(posedge clock_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         serial_clock_out <= 1'b0;
         serial_clock_oe_out <= 1'b0;
      end else begin
         serial_clock_oe_out <= sync_r && !ext_src && div_r != 16'h0000;
         if (!sync_r || ext_src || div_r == 16'h0000) begin
            serial_clock_out <= 1'b0;
         end else if (div_r == 16'h0001 && src_sel_r == ubrg_pkg::SRC_MASTER) begin
            serial_clock_out <= ~serial_clock_out; // best effort at bypass rate
         end else if (tick_if.tick) begin
            serial_clock_out <= 1'b1;
         end else if (tick_if.half_tick) begin // see [RQ12] [RQ13]
            serial_clock_out <= 1'b0;
         end
      end
   end
endmodule : ubrg_top
`default_nettype wire

// [verif/ubrg_sck_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ubrg_sck_model #(
   parameter int HALF_NS = 50
) (
   input wire logic en_in, // run the pin clock
   output logic sck_out    // serial clock pin level
);
   // ten master cycles a period; idles low between runs
   initial begin
      sck_out = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         sck_out = en_in ? ~sck_out : 1'b0;
      end
   end
endmodule : ubrg_sck_model
`default_nettype wire

// [verif/ubrg_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ubrg_asserts (
   input wire logic clock_in, // clock
   input wire logic arst_n_in, // reset
   input wire logic clk_run_in, // run
   input wire logic [1:0] clock_source_select_in, // source
   input wire logic [15:0] integer_divisor_in, // divisor
   input wire logic [2:0] fraction_eighths_in, // fraction
   input wire logic sync_mode_in, // sync
   input wire logic oversample8_in, // 8x
   input wire logic normal_mode_in, // normal
   input wire logic serial_clock_in, // pin in
   input wire logic sample_tick_out, // sample
   input wire logic bit_tick_out, // bit
   input wire logic serial_clock_out, // pin out
   input wire logic serial_clock_oe_out // pin enable
);
   wire logic ext_sync = sync_mode_in && clock_source_select_in == 2'h3;
   wire logic mast = clk_run_in && clock_source_select_in == 2'h0 && !sync_mode_in
      && fraction_eighths_in == 3'h0;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   // five-cycle windows cover the settings pipeline
   a_zero_div_quiet: assert property ((integer_divisor_in == 16'h0000 && !ext_sync)[*5]
      |-> !sample_tick_out && !bit_tick_out) else $error("tick with zero divisor");
   a_run_low_hold: assert property ((!clk_run_in)[*5]
      |-> !sample_tick_out && !bit_tick_out) else $error("tick while gated");
   a_bit_on_sample: assert property ((!sync_mode_in)[*5] ##0 bit_tick_out
      |-> sample_tick_out) else $error("bit tick off sample tick");
   a_sync_no_sample: assert property (sync_mode_in[*5] |-> !sample_tick_out)
      else $error("sample tick in sync mode");
   a_div_one_pass: assert property ((mast && integer_divisor_in == 16'h0001)[*5]
      |-> sample_tick_out) else $error("divisor one not every cycle");
   a_tick_single: assert property ((mast && integer_divisor_in > 16'h0001)[*5]
      ##0 sample_tick_out |=> !sample_tick_out) else $error("tick longer than a cycle");
   a_oe_sync_int: assert property ((sync_mode_in && clock_source_select_in != 2'h3
      && integer_divisor_in != 16'h0000)[*5] |-> serial_clock_oe_out) else $error("pin not driven");
   a_oe_async_off: assert property ((!sync_mode_in)[*5] |-> !serial_clock_oe_out)
      else $error("pin driven in async mode");
   // bit tick is registered off the edge detect: one cycle after the sampled rise
   a_ext_pin_bit: assert property ((clk_run_in && ext_sync)[*5] ##0 $rose(serial_clock_in)
      |-> ##1 bit_tick_out) else $error("pin edge gave no bit tick");
   c_frac: cover property (fraction_eighths_in != 3'h0 && sample_tick_out);
   c_ext: cover property (ext_sync && bit_tick_out);
   c_gate: cover property (!clk_run_in ##1 clk_run_in);
endmodule : ubrg_asserts
bind ubrg_top ubrg_asserts chk (.*);
`default_nettype wire

// [verif/ubrg_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ubrg_bench;
   logic clock_in, arst_n_in, clk_run_in, sync_mode_in, oversample8_in, normal_mode_in, sck_en;
   logic [1:0] clock_source_select_in;
   logic [15:0] integer_divisor_in;
   logic [2:0] fraction_eighths_in;
   wire logic serial_clock_in, sample_tick_out, bit_tick_out, serial_clock_out, serial_clock_oe_out;
   int mismatches, n_checks, p, s;
   logic [7:0] n;
   ubrg_top dut (.*);
   ubrg_sck_model pin (.en_in(sck_en), .sck_out(serial_clock_in));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cfg(input logic [1:0] sr, input logic [15:0] d, input logic [2:0] f,
      input logic sy, input logic ov, input logic nm);
      @(negedge clock_in);
      clock_source_select_in = sr;
      integer_divisor_in = d;
      fraction_eighths_in = f;
      sync_mode_in = sy;
      oversample8_in = ov;
      normal_mode_in = nm;
      repeat (4) @(negedge clock_in);
   endtask : cfg
   // bounded wait: a dead divider cannot hang the run
   task automatic next_tick(input bit b, output int k);
      k = 0;
      do begin
         @(negedge clock_in);
         k++;
      end while ((b ? bit_tick_out : sample_tick_out) !== 1'b1 && k < 4000);
   endtask : next_tick
   task automatic quiet(input int c);
      n = 8'h00;
      repeat (c) begin
         @(negedge clock_in);
         n = n + {7'h00, sample_tick_out | bit_tick_out};
      end
   endtask : quiet
   task automatic t_async;
      for (int i = 0; i < 4; i++) begin
         cfg(2'h0, i[0] ? 16'h0003 : 16'h0001, 3'h0, 1'b0, i[1], 1'b1);
         repeat (3) next_tick(0, p);
         check(p, i[0] ? 3 : 1);
         repeat (3) next_tick(1, p);
         check(p, (i[1] ? 8 : 16) * (i[0] ? 3 : 1));
      end
      $display("async rates done");
   endtask : t_async
   task automatic t_source;
      for (int i = 1; i < 3; i++) begin
         cfg(i[1:0], 16'h0002, 3'h0, 1'b0, 1'b0, 1'b1);
         repeat (3) next_tick(0, p);
         check(p, 16);
      end
      sck_en = 1'b1;
      cfg(2'h3, 16'h0001, 3'h0, 1'b0, 1'b0, 1'b1);
      repeat (3) next_tick(0, p);
      check(p, 10);
      cfg(2'h3, 16'h0000, 3'h0, 1'b1, 1'b0, 1'b1);
      repeat (3) next_tick(1, p);
      check(p, 10);
      sck_en = 1'b0;
      $display("sources done");
   endtask : t_source
   task automatic t_frac;
      for (int j = 0; j < 2; j++) begin
         cfg(2'h0, 16'h0002, 3'h3, 1'b0, 1'b0, j[0]);
         next_tick(0, p);
         s = 0;
         repeat (8) begin
            next_tick(0, p);
            s += p;
         end
         check(s, j ? 19 : 16);
      end
      $display("fraction done");
   endtask : t_frac
   task automatic t_sync;
      cfg(2'h0, 16'h0004, 3'h3, 1'b1, 1'b0, 1'b1);
      repeat (3) next_tick(1, p);
      check(p, 4);
      check(serial_clock_oe_out, 1'b1);
      // two divide periods: pin high for exactly half of them
      s = 0;
      repeat (8) begin
         @(negedge clock_in);
         s += serial_clock_out;
      end
      check(s, 4);
      // even divisor with prescaled source: bit tick every 16 cycles
      cfg(2'h1, 16'h0002, 3'h0, 1'b1, 1'b0, 1'b1);
      repeat (3) next_tick(1, p);
      check(p, 16);
      cfg(2'h0, 16'h0000, 3'h0, 1'b1, 1'b0, 1'b1);
      check(serial_clock_oe_out, 1'b0);
      cfg(2'h0, 16'h0000, 3'h0, 1'b0, 1'b0, 1'b1);
      quiet(100);
      check(n, 8'h00);
      $display("sync and zero done");
   endtask : t_sync
   task automatic t_gate;
      cfg(2'h0, 16'h0006, 3'h0, 1'b0, 1'b0, 1'b1);
      repeat (2) next_tick(0, p);
      repeat (2) @(negedge clock_in);
      clk_run_in = 1'b0;
      quiet(20);
      check(n, 8'h00);
      clk_run_in = 1'b1;
      next_tick(0, p);
      check(p, 4);
      clk_run_in = 1'b0;
      integer_divisor_in = 16'h0004;
      repeat (5) @(negedge clock_in);
      clk_run_in = 1'b1;
      repeat (3) next_tick(0, p);
      check(p, 4);
      $display("gating done");
   endtask : t_gate
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #1_000_000;
      mismatches++;
      complete_run();
   end
   initial begin
      {arst_n_in, sync_mode_in, oversample8_in, sck_en, clock_source_select_in} = '0;
      {clk_run_in, normal_mode_in} = 2'h3;
      integer_divisor_in = 16'h0000;
      fraction_eighths_in = 3'h0;
      mismatches = 0;
      n_checks = 0;
      repeat (16) @(negedge clock_in);
      arst_n_in = 1'b1;
      // exact divisors only, so baud error stays zero
      // block has no interrupt line to drive level or edge
      t_async();
      t_source();
      t_frac();
      t_sync();
      t_gate();
      complete_run();
   end
endmodule : ubrg_bench
`default_nettype wire
